// file: core/fts_pkg.sv
// Constants, state codes and timing for the fuser temperature supervisor.
// Assumes 12-bit thermistor codes on a 0 to 5 V scale and a 250 MHz clock.
package fts_pkg;

   // ==========================================================
   // Thermistor code points
   // ==========================================================
   // Seven belt temperatures as 12-bit codes of a 5 V scale.
   localparam int ADC_W = 12;
   localparam logic [11:0] CODE_40C = 12'h0f6; // About 0.30 V.
   localparam logic [11:0] CODE_100C = 12'h5aa; // About 1.77 V.
   localparam logic [11:0] CODE_150C = 12'ha7e; // About 3.28 V.
   localparam logic [11:0] CODE_170C = 12'hbb6; // About 3.66 V.
   localparam logic [11:0] CODE_180C = 12'hc30; // About 3.81 V.
   localparam logic [11:0] CODE_200C = 12'hce5; // About 4.03 V.
   localparam logic [11:0] CODE_250C = 12'hf00;
   localparam logic [11:0] CODE_OPEN = 12'h020;
   localparam logic [11:0] CODE_COIL_LIM = 12'he00;
   localparam logic [12:0] HYST = 13'h0010;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_NS = 4;
   localparam int SAMPLE_NS = 1000000;
   localparam int SAMPLE_CYC_DEF = SAMPLE_NS / CLK_NS;
   localparam int MS_PER_MIN_DEF = 60000;
   localparam int WARM_LIMIT_MS = 60000;
   localparam logic [7:0] SAVE_MIN_DEF = 8'h0f;
   localparam logic [7:0] OFF_MIN_DEF = 8'h3c;
   localparam int OFF_SEQ_NS = 100;
   localparam int OFF_SEQ_CYC = (OFF_SEQ_NS + CLK_NS - 1) / CLK_NS;

   // ==========================================================
   // Fault status counter values
   // ==========================================================
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_ONE = 5'h01;
   localparam logic [4:0] CNT_LOCK = 5'h02;
   localparam logic [4:0] CNT_HSC_FIRST = 5'h0a;
   localparam logic [4:0] CNT_HSC_LAST = 5'h11;
   localparam logic [4:0] CNT_MAX = 5'h1d;
   localparam logic [4:0] CNT_CORRUPT = 5'h1e;
   localparam logic [4:0] OVH_CNT_INIT = 5'h09;
   localparam logic [4:0] OVH_CNT_40 = 5'h13;
   localparam logic [4:0] OVH_CNT_100 = 5'h15;
   localparam logic [4:0] OVH_CNT_READY = 5'h17;
   localparam logic [4:0] OVH_CNT_PRINT = 5'h19;
   localparam logic [4:0] OVH_CNT_SAVE = 5'h1b;
   localparam logic [4:0] OVH_CNT_OFF = 5'h1d;

   typedef enum logic [3:0] {
      ST_INIT = 4'h0,
      ST_WARM = 4'h1,
      ST_READY = 4'h2,
      ST_PRINT = 4'h3,
      ST_SAVE = 4'h4,
      ST_SHUTOFF = 4'h5,
      ST_FAULT = 4'h6,
      ST_OVH_REC = 4'h7,
      ST_OVH_OUT = 4'h8,
      ST_OVH_PWR = 4'h9
   } fts_state_t;

endpackage : fts_pkg

// file: core/fts_chan_if.sv
// Flags of one thermistor channel passed to the supervisor.
// Assumes one channel module drives the flags and the supervisor the target.
`timescale 1ns/100ps
interface fts_chan_if;
   logic [11:0] tgt;
   logic broken;
   logic low;
   logic cold;
   logic hot;
   logic at_tgt;
   logic over;
   modport chan (input tgt, output broken, low, cold, hot, at_tgt, over);
   modport ctl (output tgt, input broken, low, cold, hot, at_tgt, over);
endinterface : fts_chan_if

// file: core/fts_therm_chan.sv
// One thermistor channel: synchroniser and threshold comparisons.
// Assumes raw_code comes from an ADC outside the ref_clk domain.
`timescale 1ns/100ps
module fts_therm_chan
   import fts_pkg::*;
#(
   parameter logic [11:0] OVER_CODE = CODE_250C
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [11:0] raw_code,
   fts_chan_if.chan cif
);

   logic [11:0] s1_q, s2_q;
   logic [5:0] flg_q, flg_d;
   logic [12:0] up_w, tgt_w;

   // ==========================================================
   // Comparisons
   // ==========================================================
   // Only the second synchroniser stage feeds the comparators.
   always_comb begin
      up_w = {1'b0, s2_q} + HYST;
      tgt_w = {1'b0, cif.tgt};
      flg_d[0] = s2_q < CODE_OPEN; // An open sensor reads cold.
      flg_d[1] = s2_q <= CODE_40C;
      flg_d[2] = up_w < tgt_w; // Band below target.
      flg_d[3] = {1'b0, s2_q} > tgt_w + HYST;
      flg_d[4] = s2_q >= cif.tgt;
      flg_d[5] = s2_q >= OVER_CODE;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s1_q <= 12'h000;
         s2_q <= 12'h000;
         flg_q <= 6'h00;
      end else begin
         s1_q <= raw_code;
         s2_q <= s1_q;
         flg_q <= flg_d;
      end
   end

   assign cif.broken = flg_q[0];
   assign cif.low = flg_q[1];
   assign cif.cold = flg_q[2];
   assign cif.hot = flg_q[3];
   assign cif.at_tgt = flg_q[4];
   assign cif.over = flg_q[5];

endmodule : fts_therm_chan

// file: core/fts_supervisor.sv
// Fuser heater supervisor: regulation, idle modes, fault counter.
// Assumes nonvolatile storage answers nvm_rd_valid after reset and takes
// nvm_wr_en pulses; print and service inputs are on ref_clk.
`timescale 1ns/100ps
module fts_supervisor
   import fts_pkg::*;
#(
   parameter int SAMPLE_CYC = SAMPLE_CYC_DEF,
   parameter int MS_PER_MIN = MS_PER_MIN_DEF,
   parameter logic [7:0] OFF_MIN = OFF_MIN_DEF,
   parameter logic [11:0] COIL_LIMIT = CODE_COIL_LIM
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [11:0] main_code,
   input wire logic [11:0] sub_code,
   input wire logic [11:0] edge_code,
   input wire logic [11:0] coil_code,
   input wire logic [11:0] ready_target,
   input wire logic [7:0] save_idle_min,
   input wire logic [7:0] shutoff_idle_min,
   input wire logic print_req,
   input wire logic print_done,
   input wire logic nvm_rd_valid,
   input wire logic [4:0] nvm_rd_cnt,
   input wire logic hsc_repaired,
   input wire logic svc_clear_cnt,
   output logic induction_heater_coil,
   output logic ready,
   output logic printing,
   output logic save_mode,
   output logic shutoff_mode,
   output logic thermistor_low_fault,
   output logic thermistor_lockout_fault,
   output logic overheat_fault,
   output logic therm_broken,
   output logic nvm_corrupt,
   output logic nvm_wr_en,
   output logic [4:0] nvm_wr_cnt,
   output logic [4:0] fault_cnt,
   output logic outputs_off,
   output logic main_power_off
);

   // ==========================================================
   // Channels
   // ==========================================================
   fts_chan_if main_if ();
   fts_chan_if sub_if ();
   fts_chan_if edge_if ();
   fts_chan_if coil_if ();

   fts_state_t st_q, st_d;
   logic [11:0] tgt_w;

   // Power save regulates to the lower point, all else to the set target.
   assign tgt_w = (st_q == ST_SAVE) ? CODE_100C : ready_target;
   assign main_if.tgt = tgt_w;
   assign sub_if.tgt = tgt_w;
   assign edge_if.tgt = tgt_w;
   assign coil_if.tgt = COIL_LIMIT;

   fts_therm_chan #(.OVER_CODE(CODE_250C)) u_main (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .raw_code(main_code),
      .cif(main_if)
   );
   fts_therm_chan #(.OVER_CODE(CODE_250C)) u_sub (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .raw_code(sub_code),
      .cif(sub_if)
   );
   fts_therm_chan #(.OVER_CODE(CODE_250C)) u_edge (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .raw_code(edge_code),
      .cif(edge_if)
   );
   fts_therm_chan #(.OVER_CODE(COIL_LIMIT)) u_coil (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .raw_code(coil_code),
      .cif(coil_if)
   );

   // ==========================================================
   // Derived conditions
   // ==========================================================
   logic broken_any, ovh_any, cut_w, run_st, reg_st, ms_tick;
   logic [31:0] tick_q, tick_d, ms_q, ms_d, save_lim, off_lim;
   logic [7:0] save_min_w, off_min_w;

   assign broken_any = main_if.broken | sub_if.broken | edge_if.broken |
      coil_if.broken;
   // A hot coil is handled as an overheat so power is removed.
   assign ovh_any = main_if.over | sub_if.over | coil_if.over;
   // Edge zone cut-off ignores the paper-path reading.
   assign cut_w = edge_if.over | broken_any | coil_if.over;
   assign run_st = (st_q == ST_WARM) || (st_q == ST_READY) ||
      (st_q == ST_PRINT) || (st_q == ST_SAVE) || (st_q == ST_SHUTOFF);
   assign reg_st = run_st && (st_q != ST_SHUTOFF);

   // A zero setting selects the default idle time.
   assign save_min_w = (save_idle_min == 8'h00) ? SAVE_MIN_DEF : save_idle_min;
   assign off_min_w = (shutoff_idle_min == 8'h00) ? OFF_MIN : shutoff_idle_min;
   assign save_lim = 32'(save_min_w) * 32'(MS_PER_MIN);
   assign off_lim = 32'(off_min_w) * 32'(MS_PER_MIN);

   // ==========================================================
   // Sample tick and state timer
   // ==========================================================
   // One fixed sample period paces regulation and the warm-up and idle timers; the overheat power-off delay counts clocks.
   assign ms_tick = (tick_q == 32'(SAMPLE_CYC - 1));

   always_comb begin
      tick_d = ms_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tick_q <= 32'h0000_0000;
      end else begin
         tick_q <= tick_d;
      end
   end

   // ==========================================================
   // Supervisor state machine
   // ==========================================================
   logic [4:0] cnt_q, cnt_d, wr_cnt_q, wr_cnt_d, ph_cnt;
   logic wr_en_q, wr_en_d, lowf_q, lowf_d, lock_q, lock_d;
   logic ovh_q, ovh_d, bad_q, bad_d, offs_q, offs_d, pwr_q, pwr_d;
   logic [7:0] seq_q, seq_d;

   // The counter stored on overheat names the phase it struck in.
   always_comb begin
      case (st_q)
         ST_WARM: ph_cnt = main_if.low ? OVH_CNT_40 : OVH_CNT_100;
         ST_READY: ph_cnt = OVH_CNT_READY;
         ST_PRINT: ph_cnt = OVH_CNT_PRINT;
         ST_SAVE: ph_cnt = OVH_CNT_SAVE;
         ST_SHUTOFF: ph_cnt = OVH_CNT_OFF;
         default: ph_cnt = OVH_CNT_INIT;
      endcase
   end

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ms_d = ms_tick ? ms_q + 32'h0000_0001 : ms_q;
      wr_en_d = 1'b0;
      wr_cnt_d = wr_cnt_q;
      lowf_d = lowf_q;
      lock_d = lock_q;
      ovh_d = ovh_q;
      bad_d = bad_q;
      offs_d = offs_q;
      pwr_d = pwr_q;
      seq_d = seq_q;
      case (st_q)
         // The stored counter decides start-up before the coil may heat.
         ST_INIT: begin
            ms_d = 32'h0000_0000;
            if (nvm_rd_valid) begin
               cnt_d = nvm_rd_cnt;
               if (ovh_any) begin
                  cnt_d = OVH_CNT_INIT; // Still hot at power-on.
                  st_d = ST_OVH_REC;
               end else if (nvm_rd_cnt >= CNT_CORRUPT) begin
                  bad_d = 1'b1; // Not a fault state: storage is suspect.
                  st_d = ST_FAULT;
               end else if (hsc_repaired && nvm_rd_cnt >= CNT_HSC_FIRST &&
                            nvm_rd_cnt <= CNT_HSC_LAST) begin
                  cnt_d = CNT_ZERO;
                  wr_en_d = 1'b1;
                  wr_cnt_d = CNT_ZERO;
                  st_d = ST_WARM;
               end else if (nvm_rd_cnt == CNT_LOCK) begin
                  lock_d = 1'b1; // Third attempt after two low faults.
                  st_d = ST_FAULT;
               end else if (nvm_rd_cnt > CNT_LOCK) begin
                  st_d = ST_FAULT;
               end else begin
                  st_d = ST_WARM;
               end
            end
         end
         ST_WARM: begin
            if (main_if.at_tgt && !sub_if.low) begin
               st_d = ST_READY;
               ms_d = 32'h0000_0000;
               if (cnt_q <= CNT_ONE) begin
                  cnt_d = CNT_ZERO;
                  wr_en_d = 1'b1;
                  wr_cnt_d = CNT_ZERO;
               end
            end else if (ms_q >= 32'(WARM_LIMIT_MS) &&
                         (main_if.low || sub_if.low)) begin
               cnt_d = cnt_q + CNT_ONE; // Counts toward lockout.
               wr_en_d = 1'b1;
               wr_cnt_d = cnt_q + CNT_ONE;
               lowf_d = 1'b1;
               st_d = ST_FAULT;
            end
         end
         ST_READY: begin
            if (print_req) begin
               st_d = ST_PRINT;
            end else if (ms_q >= save_lim) begin
               st_d = ST_SAVE;
               ms_d = 32'h0000_0000;
            end
         end
         ST_PRINT: begin
            if (print_done) begin
               st_d = ST_READY; // Idle time runs from print completion.
               ms_d = 32'h0000_0000;
            end
         end
         ST_SAVE: begin
            if (print_req) begin
               st_d = ST_WARM;
               ms_d = 32'h0000_0000;
            end else if (ms_q >= off_lim) begin
               st_d = ST_SHUTOFF;
            end
         end
         ST_SHUTOFF: begin
            if (print_req) begin
               st_d = ST_WARM;
               ms_d = 32'h0000_0000;
            end
         end
         ST_FAULT: begin
            if (svc_clear_cnt) begin
               lowf_d = 1'b0;
               lock_d = 1'b0;
               bad_d = 1'b0;
               st_d = ST_WARM;
               ms_d = 32'h0000_0000;
            end
         end
         // Record first, then drop outputs, then main power.
         ST_OVH_REC: begin
            wr_en_d = 1'b1;
            wr_cnt_d = cnt_q;
            ovh_d = 1'b1;
            seq_d = 8'h00;
            st_d = ST_OVH_OUT;
         end
         ST_OVH_OUT: begin
            offs_d = 1'b1;
            if (seq_q == 8'(OFF_SEQ_CYC - 1)) begin
               pwr_d = 1'b1;
               st_d = ST_OVH_PWR;
            end else begin
               seq_d = seq_q + 8'h01;
            end
         end
         // Powered off; only a power cycle leaves, and INIT rechecks heat.
         ST_OVH_PWR: begin
            st_d = ST_OVH_PWR;
         end
         default: st_d = ST_INIT;
      endcase
      // Service write of zero works in the running states and in fault, not in init or overheat.
      if (svc_clear_cnt && (run_st || st_q == ST_FAULT)) begin
         cnt_d = CNT_ZERO;
         wr_en_d = 1'b1;
         wr_cnt_d = CNT_ZERO;
      end
      // Overheat overrides every running phase.
      if (run_st && ovh_any) begin
         cnt_d = ph_cnt;
         st_d = ST_OVH_REC;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= ST_INIT;
         cnt_q <= CNT_ZERO;
         ms_q <= 32'h0000_0000;
         wr_en_q <= 1'b0;
         wr_cnt_q <= CNT_ZERO;
         lowf_q <= 1'b0;
         lock_q <= 1'b0;
         ovh_q <= 1'b0;
         bad_q <= 1'b0;
         offs_q <= 1'b0;
         pwr_q <= 1'b0;
         seq_q <= 8'h00;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ms_q <= ms_d;
         wr_en_q <= wr_en_d;
         wr_cnt_q <= wr_cnt_d;
         lowf_q <= lowf_d;
         lock_q <= lock_d;
         ovh_q <= ovh_d;
         bad_q <= bad_d;
         offs_q <= offs_d;
         pwr_q <= pwr_d;
         seq_q <= seq_d;
      end
   end

   // ==========================================================
   // Coil regulation
   // ==========================================================
   logic heat_q, heat_d;

   // Hysteresis around the target, decided once per sample period, so
   // the coil enable cannot chatter; cut-offs act on every clock.
   always_comb begin
      heat_d = heat_q;
      if (!reg_st || cut_w || ovh_any) begin
         heat_d = 1'b0;
      end else if (ms_tick) begin
         if (main_if.cold) begin
            heat_d = 1'b1;
         end else if (main_if.hot) begin
            heat_d = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         heat_q <= 1'b0;
      end else begin
         heat_q <= heat_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign induction_heater_coil = heat_q;
   assign ready = (st_q == ST_READY);
   assign printing = (st_q == ST_PRINT);
   assign save_mode = (st_q == ST_SAVE);
   assign shutoff_mode = (st_q == ST_SHUTOFF);
   assign thermistor_low_fault = lowf_q;
   assign thermistor_lockout_fault = lock_q;
   assign overheat_fault = ovh_q;
   assign therm_broken = broken_any;
   assign nvm_corrupt = bad_q;
   assign nvm_wr_en = wr_en_q;
   assign nvm_wr_cnt = wr_cnt_q;
   assign fault_cnt = cnt_q;
   assign outputs_off = offs_q;
   assign main_power_off = pwr_q;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence ovh_rec_s;
      st_q == ST_OVH_REC;
   endsequence
   sequence ovh_down_s;
      (nvm_wr_en && !outputs_off) ##1 (outputs_off && !main_power_off);
   endsequence

   ovh_order_a: assert property (
      ovh_rec_s |=> ovh_down_s ##[1:40] main_power_off)
      else $error("Overheat shutdown order broken.");
   edge_cut_a: assert property (edge_if.over |=> !heat_q)
      else $error("Coil on with edge zone over limit.");
   broken_cut_a: assert property (broken_any |=> !heat_q)
      else $error("Coil on with a broken thermistor.");
   coil_limit_a: assert property (
      (coil_if.over && run_st) |=> st_q == ST_OVH_REC ##2 outputs_off)
      else $error("Coil over limit did not start shutdown.");
   save_target_a: assert property (save_mode |-> tgt_w == CODE_100C)
      else $error("Power save target not 100 C.");
   shutoff_cold_a: assert property (
      (st_q == ST_SHUTOFF) [*2] |-> !heat_q)
      else $error("Coil on in shut-off mode.");
   wake_up_a: assert property (
      ((save_mode || shutoff_mode) && print_req && !ovh_any)
      |=> st_q == ST_WARM)
      else $error("Print request did not wake the fuser.");
   idle_save_a: assert property (
      (ready && !print_req && !ovh_any && ms_q >= save_lim) |=> save_mode)
      else $error("Idle time passed without power save.");
   lock_off_a: assert property (lock_q |-> !heat_q)
      else $error("Coil on during lockout.");
   ready_clear_a: assert property (
      (st_q == ST_WARM && cnt_q <= CNT_ONE) ##1 ready |-> cnt_q == CNT_ZERO)
      else $error("Counter not cleared on normal ready.");
   cnt_range_a: assert property (!bad_q |-> cnt_q <= CNT_MAX)
      else $error("Counter outside 0 to 29.");
   corrupt_hold_a: assert property (bad_q |-> !heat_q && !ready)
      else $error("Corrupt counter treated as valid.");
   hsc_clear_a: assert property (
      (st_q == ST_INIT && nvm_rd_valid && !ovh_any && hsc_repaired &&
       nvm_rd_cnt >= CNT_HSC_FIRST && nvm_rd_cnt <= CNT_HSC_LAST)
      |=> nvm_wr_en && nvm_wr_cnt == CNT_ZERO)
      else $error("Repaired service call counter not cleared.");
   ovh_value_a: assert property (
      $rose(ovh_q) |-> nvm_wr_cnt inside {5'h09, 5'h13, 5'h15, 5'h16,
      5'h17, 5'h19, 5'h1b, 5'h1d})
      else $error("Overheat counter value not in set.");
   hot_start_a: assert property (
      (st_q == ST_INIT && nvm_rd_valid && ovh_any) |=> st_q == ST_OVH_REC)
      else $error("Hot power-on did not shut down.");
   heat_tick_a: assert property ($rose(heat_q) |-> $past(ms_tick))
      else $error("Coil switched on off the sample tick.");

endmodule : fts_supervisor

// file: verification/fts_belt_model.sv
// Behavioural fuser belt and heater board for the supervisor bench.
// Assumes one ref_clk; a nonzero forced code overrides the belt reading.
`timescale 1ns/100ps
module fts_belt_model
   import fts_pkg::*;
(
   input wire logic ref_clk,
   input wire logic coil_on,
   input wire logic [11:0] force_code,
   output logic [11:0] belt_code
);
   logic [11:0] temp_q = 12'h100;
   // =====
   // Belt heat
   // Fast rise and slow cooling, so regulation settles near its target.
   always_ff @(posedge ref_clk) begin
      if (coil_on && temp_q < 12'hef0)
         temp_q <= temp_q + 12'h008;
      else if (!coil_on && temp_q > CODE_40C)
         temp_q <= temp_q - 12'h001;
   end
   // A forced code stands for an overheated belt.
   assign belt_code = (force_code != 12'h000) ? force_code : temp_q;
endmodule : fts_belt_model

// file: verification/testbench.sv
// Self-checking bench for the fuser supervisor with a belt model.
// Assumes a four-cycle sample tick and three ticks to the minute.
`timescale 1ns/100ps
module testbench;
   import fts_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] main_v, frc = 12'h000, edge_v = 12'h100, tgt = 12'h800;
   logic [11:0] coil_v = 12'h100;
   logic svc = 1'b0, nvm_we;
   logic [4:0] nvm_wc;
   logic [7:0] save_m = 8'h00, off_m = 8'h0a;
   logic preq = 1'b0, pdone = 1'b0, rdv = 1'b0, hsc = 1'b0;
   logic [4:0] rdc = 5'h00, fault_cnt;
   logic coil, ready, printing, save_mode, shutoff_mode, lockf, ovf;
   logic brk, corrupt, outputs_off, pwr_off;
   int bad_count = 0;
   int tests_run = 0;
   // =====
   // Design and belt
   fts_supervisor #(.SAMPLE_CYC(4), .MS_PER_MIN(3)) i_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .main_code(main_v),
      .sub_code(main_v), .edge_code(edge_v), .coil_code(coil_v),
      .ready_target(tgt), .save_idle_min(save_m),
      .shutoff_idle_min(off_m), .print_req(preq), .print_done(pdone),
      .nvm_rd_valid(rdv), .nvm_rd_cnt(rdc), .hsc_repaired(hsc),
      .svc_clear_cnt(svc), .induction_heater_coil(coil), .ready(ready),
      .printing(printing), .save_mode(save_mode),
      .shutoff_mode(shutoff_mode), .thermistor_low_fault(),
      .thermistor_lockout_fault(lockf), .overheat_fault(ovf),
      .therm_broken(brk), .nvm_corrupt(corrupt), .nvm_wr_en(nvm_we),
      .nvm_wr_cnt(nvm_wc), .fault_cnt(fault_cnt), .outputs_off(outputs_off),
      .main_power_off(pwr_off));
   fts_belt_model i_belt (.ref_clk(ref_clk), .coil_on(coil),
      .force_code(frc), .belt_code(main_v));
   // Free-running clock, inputs move on the falling edge.
   initial forever #2 ref_clk = ~ref_clk;
   task automatic cyc(int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic check(string nm, logic [4:0] exp, logic [4:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // Reset long enough for the channel synchronisers, then one read.
   task automatic boot(logic [4:0] c, logic h);
      sys_rst = 1'b1;
      rdc = c;
      hsc = h;
      cyc(20);
      sys_rst = 1'b0;
      cyc(4);
      rdv = 1'b1;
      cyc(1);
      rdv = 1'b0;
      cyc(4);
   endtask : boot
   task automatic t_boot;
      boot(5'h02, 1'b0);
      check("lockout", 5'h01, 5'(lockf));
      check("lock coil", 5'h00, 5'(coil));
      // A service clear pulse writes zero and lifts the lockout.
      svc = 1'b1;
      cyc(1);
      svc = 1'b0;
      check("svc write", 5'h01, 5'(nvm_we));
      check("svc value", 5'h00, nvm_wc);
      check("svc unlock", 5'h00, 5'(lockf));
      boot(5'h1e, 1'b0);
      check("corrupt", 5'h01, 5'(corrupt));
      boot(5'h0b, 1'b1);
      check("repaired cnt", 5'h00, fault_cnt);
      $display("test boot ended");
   endtask : t_boot
   task automatic t_warm;
      int n;
      boot(5'h01, 1'b0);
      check("warm coil", 5'h01, 5'(coil));
      for (n = 0; n < 1000 && ready !== 1'b1; n++)
         cyc(1);
      check("ready", 5'h01, 5'(ready));
      check("ready cnt", 5'h00, fault_cnt);
      tgt = 12'ha00;
      cyc(10);
      check("regulate", 5'h01, 5'(coil));
      edge_v = CODE_250C;
      cyc(5);
      check("edge cut", 5'h00, 5'(coil));
      edge_v = 12'h000;
      cyc(5);
      check("broken", 5'h01, 5'(brk));
      check("broken coil", 5'h00, 5'(coil));
      edge_v = 12'h100;
      tgt = 12'h800;
      cyc(10);
      $display("test warm ended");
   endtask : t_warm
   task automatic t_idle;
      int n;
      preq = 1'b1;
      cyc(3);
      check("printing", 5'h01, 5'(printing));
      preq = 1'b0;
      pdone = 1'b1;
      cyc(1);
      pdone = 1'b0;
      for (n = 0; n < 400 && save_mode !== 1'b1; n++)
         cyc(1);
      check("save time", 5'h01, 5'(n > 170 && n < 190));
      cyc(20);
      check("save coil", 5'h00, 5'(coil));
      for (n = 0; n < 200 && shutoff_mode !== 1'b1; n++)
         cyc(1);
      check("shutoff", 5'h01, 5'(shutoff_mode));
      check("shutoff coil", 5'h00, 5'(coil));
      preq = 1'b1;
      cyc(2);
      preq = 1'b0;
      check("wake", 5'h00, 5'(shutoff_mode | save_mode));
      for (n = 0; n < 1000 && ready !== 1'b1; n++)
         cyc(1);
      check("rewarm", 5'h01, 5'(ready));
      $display("test idle ended");
   endtask : t_idle
   task automatic t_ovh;
      int n;
      frc = CODE_250C;
      for (n = 0; n < 10 && ovf !== 1'b1; n++)
         cyc(1);
      check("ovh cnt", 5'h17, fault_cnt);
      cyc(1);
      check("outputs off", 5'h01, 5'(outputs_off & ~pwr_off));
      cyc(23);
      check("power early", 5'h00, 5'(pwr_off));
      cyc(1);
      check("power off", 5'h01, 5'(pwr_off));
      boot(5'h00, 1'b0);
      check("hot boot cnt", 5'h09, fault_cnt);
      cyc(30);
      check("hot boot off", 5'h01, 5'(pwr_off));
      frc = 12'h000;
      // A hot coil while running starts the same shutdown.
      boot(5'h00, 1'b0);
      coil_v = CODE_COIL_LIM;
      cyc(6);
      check("coil limit", 5'h01, 5'(outputs_off));
      coil_v = 12'h100;
      $display("test overheat ended");
   endtask : t_ovh
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   // Main sequence.
   initial begin
      t_boot();
      t_warm();
      t_idle();
      t_ovh();
      finish_test();
   end
   // Watchdog at 25000 cycles, well beyond the thousand or so cycles the tests need.
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end
endmodule : testbench
